/* hw/gpio_pkg.sv */
// package of register offsets, widths and reset values for the parallel port block
// assumes a classic wishbone slave with 32-bit data and byte-address words
package gpio_pkg;
  localparam int unsigned WIDE_W   = 8;
  localparam int unsigned SHARED_W = 6;
  localparam int unsigned ADDR_W   = 10;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_A_DATA  = 8'h00;
  localparam logic [7:0] IDX_B_DATA  = 8'h01;
  localparam logic [7:0] IDX_A_DIR   = 8'h04;
  localparam logic [7:0] IDX_B_DIR   = 8'h05;
  localparam logic [7:0] IDX_D_DATA  = 8'h30;
  localparam logic [7:0] IDX_D_DIR   = 8'h31;
  localparam logic [7:0] IDX_D_MODE  = 8'h32;
  localparam logic [7:0] IDX_D_SEL   = 8'h33;
  localparam logic [7:0] DIR_RST     = 8'h00;
  localparam logic [5:0] SHARED_RST  = 6'h00;
  // shared port line positions of the alternate functions
  localparam int unsigned POS_CAP_ONE = 0;
  localparam int unsigned POS_CMP_ONE = 1;
  localparam int unsigned POS_CAP_TWO = 2;
  localparam int unsigned POS_CMP_TWO = 3;
  localparam int unsigned POS_I2C_DAT = 4;
  localparam int unsigned POS_I2C_CLK = 5;
endpackage

/* hw/parallel_io_ports.sv */
// top of the parallel port block: two 8-line ports, one 6-line shared port, wishbone slave
// assumes pins are synchronous to clk_i and the timer and i2c units sit beside it
//
// Behaviour
// - twenty-two lines: two eight-bit, one six-bit port
// - direction one drives output, zero is input
// - reset clears every direction register to zero
// - reset leaves output latches unchanged
// - write with direction zero updates latch only
// - write with direction one drives new value
// - read of input line returns pin level
// - read of output line returns latch
// - direction registers read back last written value
// - direction and mode bits pick pull-up, open-drain
// - select bit hands pin to timer or i2c
// - line five is i2c clock, always open-drain
// - line four is i2c data, always open-drain
// - line three outputs second compare, mode chooses drain
// - line one outputs first compare, mode chooses drain
// - line two feeds second capture, pull-up mode clear
// - line zero feeds first capture, pull-up mode clear
// - clear select bit gives ordinary general-purpose line
module parallel_io_ports (
  input  wire logic                            clk_i,                   // system clock
  input  wire logic                            rstn_i,                  // async reset, active low
  input  wire logic                            cyc_i,                   // wishbone cycle
  input  wire logic                            stb_i,                   // wishbone strobe
  input  wire logic                            we_i,                    // wishbone write
  input  wire logic [gpio_pkg::ADDR_W-1:0]     adr_i,                   // wishbone byte address
  input  wire logic [3:0]                      sel_i,                   // wishbone byte select
  input  wire logic [31:0]                     dat_i,                   // wishbone write data
  output logic      [31:0]                     dat_o,                   // wishbone read data
  output logic                                 ack_o,                   // wishbone acknowledge
  input  wire logic [gpio_pkg::WIDE_W-1:0]     first_port_i,            // first port pin levels
  output logic      [gpio_pkg::WIDE_W-1:0]     first_port_o,            // first port drive values
  output logic      [gpio_pkg::WIDE_W-1:0]     first_port_oe_o,         // first port drive enables
  input  wire logic [gpio_pkg::WIDE_W-1:0]     second_port_i,           // second port pin levels
  output logic      [gpio_pkg::WIDE_W-1:0]     second_port_o,           // second port drive values
  output logic      [gpio_pkg::WIDE_W-1:0]     second_port_oe_o,        // second port drive enables
  input  wire logic [gpio_pkg::SHARED_W-1:0]   shared_port_i,           // shared port pin levels
  output logic      [gpio_pkg::SHARED_W-1:0]   shared_port_o,           // shared port drive values
  output logic      [gpio_pkg::SHARED_W-1:0]   shared_port_oe_o,        // shared port drive enables
  output logic      [gpio_pkg::SHARED_W-1:0]   shared_port_pull_en_o,   // shared port pull-up enables
  input  wire logic                            timer_compare_out_one_i, // first compare from timer
  input  wire logic                            timer_compare_out_two_i, // second compare from timer
  output logic                                 timer_capture_in_one_o,  // first capture to timer
  output logic                                 timer_capture_in_two_o,  // second capture to timer
  input  wire logic                            i2c_clock_pin_i,         // i2c clock drive, 0 pulls low
  input  wire logic                            i2c_data_pin_i,          // i2c data drive, 0 pulls low
  output logic                                 i2c_clock_pin_o,         // i2c clock line level
  output logic                                 i2c_data_pin_o           // i2c data line level
);
  localparam int unsigned SW = gpio_pkg::SHARED_W;

  // wishbone decode: printed offsets are indices, word address = index
  wire       req      = cyc_i & stb_i & ~ack_o;
  wire [7:0] idx      = adr_i[9:2];
  wire       wr       = req & we_i & sel_i[0];
  wire       hit_a_d  = idx == gpio_pkg::IDX_A_DATA;
  wire       hit_b_d  = idx == gpio_pkg::IDX_B_DATA;
  wire       hit_a_r  = idx == gpio_pkg::IDX_A_DIR;
  wire       hit_b_r  = idx == gpio_pkg::IDX_B_DIR;
  wire       hit_d_d  = idx == gpio_pkg::IDX_D_DATA;
  wire       hit_d_r  = idx == gpio_pkg::IDX_D_DIR;
  wire       hit_d_m  = idx == gpio_pkg::IDX_D_MODE;
  wire       hit_d_s  = idx == gpio_pkg::IDX_D_SEL;

  logic [7:0] a_lat, a_dir, a_rd, b_lat, b_dir, b_rd;

  // the two wide ports share one structure
  std_port_line #(.WIDTH(gpio_pkg::WIDE_W)) u_first (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .we_lat_i (wr & hit_a_d),
    .we_dir_i (wr & hit_a_r),
    .wdata_i  (dat_i[7:0]),
    .pin_i    (first_port_i),
    .pin_o    (first_port_o),
    .pin_oe_o (first_port_oe_o),
    .lat_o    (a_lat),
    .dir_o    (a_dir),
    .rd_o     (a_rd)
  );

  std_port_line #(.WIDTH(gpio_pkg::WIDE_W)) u_second (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .we_lat_i (wr & hit_b_d),
    .we_dir_i (wr & hit_b_r),
    .wdata_i  (dat_i[7:0]),
    .pin_i    (second_port_i),
    .pin_o    (second_port_o),
    .pin_oe_o (second_port_oe_o),
    .lat_o    (b_lat),
    .dir_o    (b_dir),
    .rd_o     (b_rd)
  );

  // shared port registers; latch keeps its value over reset
  logic [SW-1:0] shared_port_latch_ff;
  logic [SW-1:0] shared_port_direction_ff;
  logic [SW-1:0] shared_port_pin_mode_ff;
  logic [SW-1:0] shared_port_function_select_ff;

  always_ff @(posedge clk_i) begin
    if (wr & hit_d_d) shared_port_latch_ff <= dat_i[SW-1:0];
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shared_port_direction_ff       <= gpio_pkg::SHARED_RST;
      shared_port_pin_mode_ff        <= gpio_pkg::SHARED_RST;
      shared_port_function_select_ff <= gpio_pkg::SHARED_RST;
    end else begin
      if (wr & hit_d_r) shared_port_direction_ff <= dat_i[SW-1:0];
      if (wr & hit_d_m) shared_port_pin_mode_ff <= dat_i[SW-1:0];
      if (wr & hit_d_s) shared_port_function_select_ff <= dat_i[SW-1:0];
    end
  end

  // per-line alternate function description
  wire [SW-1:0] alt_out = 6'h3a; // lines 1,3,4,5 drive
  wire [SW-1:0] alt_od  = 6'h30; // lines 4,5 always open-drain
  wire [SW-1:0] alt_val = {i2c_clock_pin_i, i2c_data_pin_i, timer_compare_out_two_i,
                           1'b1, timer_compare_out_one_i, 1'b1};

  genvar g;
  generate
    for (g = 0; g < SW; g++) begin : g_shared
      shared_pin_cell u_cell (
        .sel_i     (shared_port_function_select_ff[g]),
        .dir_i     (shared_port_direction_ff[g]),
        .mode_i    (shared_port_pin_mode_ff[g]),
        .lat_i     (shared_port_latch_ff[g]),
        .alt_out_i (alt_out[g]),
        .alt_od_i  (alt_od[g]),
        .alt_val_i (alt_val[g]),
        .pin_o     (shared_port_o[g]),
        .pin_oe_o  (shared_port_oe_o[g]),
        .pull_en_o (shared_port_pull_en_o[g])
      );
    end
  endgenerate

  // capture and i2c receive the pin level; unselected capture idles low, unselected i2c idles high
  wire [SW-1:0] fsel = shared_port_function_select_ff;
  assign timer_capture_in_one_o = fsel[gpio_pkg::POS_CAP_ONE] ? shared_port_i[gpio_pkg::POS_CAP_ONE] : 1'b0;
  assign timer_capture_in_two_o = fsel[gpio_pkg::POS_CAP_TWO] ? shared_port_i[gpio_pkg::POS_CAP_TWO] : 1'b0;
  assign i2c_clock_pin_o = fsel[gpio_pkg::POS_I2C_CLK] ? shared_port_i[gpio_pkg::POS_I2C_CLK] : 1'b1;
  assign i2c_data_pin_o  = fsel[gpio_pkg::POS_I2C_DAT] ? shared_port_i[gpio_pkg::POS_I2C_DAT] : 1'b1;

  // shared data read-back: output lines give the latch, others the pin
  wire [SW-1:0] d_rd = (shared_port_direction_ff & shared_port_latch_ff)
                     | (~shared_port_direction_ff & shared_port_i);

  wire [7:0] rd_mux = hit_a_d ? a_rd :
                      hit_b_d ? b_rd :
                      hit_a_r ? a_dir :
                      hit_b_r ? b_dir :
                      hit_d_d ? {2'b00, d_rd} :
                      hit_d_r ? {2'b00, shared_port_direction_ff} :
                      hit_d_m ? {2'b00, shared_port_pin_mode_ff} :
                      hit_d_s ? {2'b00, shared_port_function_select_ff} : 8'h00;

  // one-wait-state slave: ack one cycle after the request, read data registered
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= {24'h00_0000, rd_mux};
    end
  end

  wire unused_lat = ^{a_lat, b_lat, sel_i[3:1], dat_i[31:8], adr_i[1:0]};
endmodule

/* hw/shared_pin_cell.sv */
// one line of the shared port: picks drive, open-drain and pull-up from select, direction and mode
// assumes the alternate unit gives a drive value and whether it needs open-drain forcing
module shared_pin_cell (
  input  wire logic sel_i,      // function select bit
  input  wire logic dir_i,      // direction bit
  input  wire logic mode_i,     // pin mode bit
  input  wire logic lat_i,      // latch bit
  input  wire logic alt_out_i,  // alternate function drives this line
  input  wire logic alt_od_i,   // alternate function is always open-drain
  input  wire logic alt_val_i,  // alternate drive value
  output logic      pin_o,      // pin drive value
  output logic      pin_oe_o,   // pin drive enable
  output logic      pull_en_o   // pull-up enable
);
  wire gp_oe   = dir_i & (~mode_i | ~lat_i);
  wire alt_od  = alt_od_i | mode_i;
  wire alt_oe  = alt_out_i & (~alt_od | ~alt_val_i);
  assign pin_oe_o  = sel_i ? alt_oe : gp_oe;
  assign pin_o     = sel_i ? (alt_od ? 1'b0 : alt_val_i) : (mode_i ? 1'b0 : lat_i);
  // pull-up only with mode bit clear and direction bit clear, or on a capture input; compare lines never get it
  assign pull_en_o = ~mode_i & (sel_i ? (alt_od_i ? ~dir_i : ~alt_out_i) : ~dir_i);
endmodule

/* hw/std_port_line.sv */
// one general-purpose port of WIDTH lines: latch, direction, pin drive and read-back
// assumes write strobes come from the bus slave and pins are synchronous inputs
module std_port_line #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_i,     // system clock
  input  wire logic             rstn_i,    // async reset, active low
  input  wire logic             we_lat_i,  // write latch strobe
  input  wire logic             we_dir_i,  // write direction strobe
  input  wire logic [WIDTH-1:0] wdata_i,   // write data
  input  wire logic [WIDTH-1:0] pin_i,     // pin level
  output logic      [WIDTH-1:0] pin_o,     // pin drive value
  output logic      [WIDTH-1:0] pin_oe_o,  // pin drive enable
  output logic      [WIDTH-1:0] lat_o,     // latch contents
  output logic      [WIDTH-1:0] dir_o,     // direction register
  output logic      [WIDTH-1:0] rd_o       // data read-back
);
  logic [WIDTH-1:0] lat_ff;
  logic [WIDTH-1:0] dir_ff;

  // latch is not reset so its contents survive reset
  always_ff @(posedge clk_i) begin
    if (we_lat_i) lat_ff <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) dir_ff <= '0;
    else if (we_dir_i) dir_ff <= wdata_i;
  end

  assign pin_o    = lat_ff;
  assign pin_oe_o = dir_ff;
  assign rd_o     = (dir_ff & lat_ff) | (~dir_ff & pin_i);
  assign lat_o    = lat_ff;
  assign dir_o    = dir_ff;
endmodule

/* verif/parallel_io_ports_chk.sv */
// checker of bus answers and port routing at the block top
// assumes one clock domain and a master that holds requests until ack
module parallel_io_ports_chk (
  input wire logic                          clk_i,                  // system clock
  input wire logic                          rstn_i,                 // async reset, active low
  input wire logic                          cyc_i,                  // bus cycle
  input wire logic                          stb_i,                  // bus strobe
  input wire logic                          we_i,                   // bus write
  input wire logic                          ack_o,                  // bus acknowledge
  input wire logic [gpio_pkg::ADDR_W-1:0]   adr_i,                  // byte address
  input wire logic [3:0]                    sel_i,                  // byte select
  input wire logic [31:0]                   dat_i,                  // write data
  input wire logic [31:0]                   dat_o,                  // read data
  input wire logic [gpio_pkg::WIDE_W-1:0]   first_port_i,           // first port pin levels
  input wire logic [gpio_pkg::WIDE_W-1:0]   first_port_o,           // first port drive values
  input wire logic [gpio_pkg::WIDE_W-1:0]   first_port_oe_o,        // first port drive enables
  input wire logic [gpio_pkg::SHARED_W-1:0] shared_port_i,          // shared port pin levels
  input wire logic [gpio_pkg::SHARED_W-1:0] shared_port_o,          // shared port drive values
  input wire logic [gpio_pkg::SHARED_W-1:0] shared_port_oe_o,       // shared port drive enables
  input wire logic                          timer_capture_in_one_o, // first capture to timer
  input wire logic                          i2c_clock_pin_i         // i2c clock drive
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [5:0] alt_ff;  // select bits as written, so routing can be judged
  wire wr = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
  wire [7:0] idx = adr_i[9:2];
  sequence s_take; cyc_i && stb_i && !ack_o; endsequence
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) alt_ff <= 6'h00;
    else if (wr && idx == gpio_pkg::IDX_D_SEL) alt_ff <= dat_i[5:0];
  a_ack_follows: assert property (s_take |=> ack_o) else $error("request not acked");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_latch_write: assert property (wr && idx == gpio_pkg::IDX_A_DATA |=> first_port_o == $past(dat_i[7:0]))
    else $error("latch write lost");
  a_dir_write: assert property (wr && idx == gpio_pkg::IDX_A_DIR |=> first_port_oe_o == $past(dat_i[7:0]))
    else $error("direction write lost");
  a_read_mix: assert property (s_take ##0 !we_i && idx == gpio_pkg::IDX_A_DATA |=> dat_o[7:0] ==
    ($past(first_port_oe_o) & $past(first_port_o) | ~$past(first_port_oe_o) & $past(first_port_i)))
    else $error("read-back wrong");
  a_top_zero: assert property (s_take ##0 !we_i && idx[7:2] == 6'h0c |=> dat_o[31:6] == 26'h0)
    else $error("unused shared bits set");
  a_cap_route: assert property (alt_ff[0] |->
    timer_capture_in_one_o == shared_port_i[0] && !shared_port_oe_o[0]) else $error("capture misrouted");
  a_i2c_drain: assert property (alt_ff[5] |-> shared_port_oe_o[5] == !i2c_clock_pin_i
    && !(shared_port_oe_o[5] && shared_port_o[5])) else $error("i2c clock not open-drain");
endmodule
bind parallel_io_ports parallel_io_ports_chk u_chk (.*);

/* verif/pin_world.sv */
// board model at the shared port: outside drivers and pull-ups
// assumes the block drives a line only while its enable is high
module pin_world (
  input  wire logic [5:0] drv_i,    // block drive values
  input  wire logic [5:0] oe_i,     // block drive enables
  input  wire logic [5:0] pull_i,   // pull-up enables
  input  wire logic [5:0] ext_i,    // outside drive values
  input  wire logic [5:0] ext_en_i, // outside drive enables
  output logic      [5:0] pin_o     // line levels
);
  // an undriven, unpulled line shows the inverse of the outside value, never a lucky guess
  assign pin_o = oe_i & drv_i | ~oe_i & (ext_en_i & ext_i | ~ext_en_i & (pull_i | ~ext_i));
endmodule

/* verif/tb_top.sv */
// bench of the parallel port block: wishbone tasks, random port traffic, shared-line modes
// assumes a one-cycle ack and the board model on the shared port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rstn_i = 0, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [3:0]  alt = 4'h3, sel_i = 4'h1;
  logic [9:0]  adr_i = 10'h000;
  logic [31:0] dat_i = 32'h0, dat_o, seed = 32'h0000d447;
  logic [23:0] ext = 24'h0;
  logic [5:0]  ext_en = 6'h0, pull;
  logic [7:0]  lats [3], dirs [3], didx [3] = '{8'h00, 8'h01, 8'h30}, ridx [3] = '{8'h04, 8'h05, 8'h31};
  logic [7:0]  zidx [6] = '{8'h04, 8'h05, 8'h31, 8'h32, 8'h33, 8'h02};
  wire  [3:0]  alt_o;
  wire  [23:0] oe_all, out_all, pin_all;
  int          err_total = 0, checks_done = 0;
  always #20 clk_i = ~clk_i;
  assign pin_all[15:0] = oe_all[15:0] & out_all[15:0] | ~oe_all[15:0] & ext[15:0];
  // the shared port has only six lines; the two spare bits of each bus read as zero
  assign {oe_all[23:22], out_all[23:22], pin_all[23:22]} = 6'h00;
  parallel_io_ports DUT (.clk_i, .rstn_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .first_port_i(pin_all[7:0]), .first_port_o(out_all[7:0]), .first_port_oe_o(oe_all[7:0]),
    .second_port_i(pin_all[15:8]), .second_port_o(out_all[15:8]), .second_port_oe_o(oe_all[15:8]),
    .shared_port_i(pin_all[21:16]), .shared_port_o(out_all[21:16]), .shared_port_oe_o(oe_all[21:16]),
    .shared_port_pull_en_o(pull), .timer_compare_out_one_i(alt[3]), .timer_compare_out_two_i(alt[2]),
    .timer_capture_in_one_o(alt_o[2]), .timer_capture_in_two_o(alt_o[3]), .i2c_clock_pin_i(alt[1]),
    .i2c_data_pin_i(alt[0]), .i2c_clock_pin_o(alt_o[1]), .i2c_data_pin_o(alt_o[0]));
  pin_world u_board (.drv_i(out_all[21:16]), .oe_i(oe_all[21:16]), .pull_i(pull), .ext_i(ext[21:16]),
    .ext_en_i(ext_en), .pin_o(pin_all[21:16]));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] rd_exp(input logic [7:0] dir, lat, pin);
    return dir & lat | ~dir & pin;
  endfunction
  task automatic chk(input logic [31:0] seen, want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, d, output logic [7:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) err_total++;
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
  initial begin
    logic [7:0] q, l, d, m;
    int k;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (zidx[i]) begin
      wb(1'b0, zidx[i], 8'h00, q);
      chk(q, 8'h00);
    end
    // a write with byte lane zero disabled must leave the direction register alone
    sel_i <= 4'h0;
    wb(1'b1, 8'h04, 8'hff, q);
    sel_i <= 4'h1;
    chk({oe_all[21:0], pull}, {22'h0, 6'h3f});
    dirs = '{default: 8'h00};
    for (int j = 0; j < 15; j++) begin
      k = j % 3;
      m = k == 2 ? 8'h3f : 8'hff;
      l = 8'(rnd());
      d = 8'(rnd());
      ext <= 24'(rnd());
      ext_en <= 6'(rnd());
      wb(1'b1, didx[k], l, q);
      chk(oe_all[k*8+:8] & out_all[k*8+:8] & m, dirs[k] & l);
      wb(1'b1, ridx[k], d, q);
      dirs[k] = d & m;
      chk(oe_all[k*8+:8] & m, dirs[k]);
      wb(1'b0, ridx[k], 8'h00, q);
      chk(q, dirs[k]);
      wb(1'b0, didx[k], 8'h00, q);
      chk(q, rd_exp(dirs[k], l, pin_all[k*8+:8]) & m);
      lats[k] = l;
    end
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(out_all[15:0], {lats[1], lats[0]});
    chk(oe_all[21:0], 22'h0);
    rstn_i <= 1'b1;
    wb(1'b1, 8'h30, l, q);
    for (int i = 0; i < 4; i++) begin
      d = i[1] ? 8'h3f : 8'h00;
      m = i[0] ? 8'h3f : 8'h00;
      wb(1'b1, 8'h31, d, q);
      wb(1'b1, 8'h32, m, q);
      chk({pull, oe_all[21:16]}, {6'(~d & ~m), 6'(d & (i[0] ? ~l : 8'hff))});
      chk(out_all[21:16] & oe_all[21:16], 6'(i[0] ? 8'h00 : d & l));
    end
    wb(1'b1, 8'h33, 8'h3f, q);
    for (int i = 0; i < 8; i++) begin
      m = i[2] ? 8'h3f : 8'h00;
      wb(1'b1, 8'h32, m, q);
      alt <= 4'(rnd());
      ext <= 24'(rnd());
      ext_en <= 6'(rnd());
      @(posedge clk_i);
      chk({alt_o[3:2], pull[2], pull[0]}, {pin_all[18], pin_all[16], ~m[2], ~m[0]});
      chk({oe_all[19], oe_all[17]}, i[2] ? {~alt[2], ~alt[3]} : 2'b11);
      chk({out_all[19] & oe_all[19], out_all[17] & oe_all[17]}, i[2] ? 2'b00 : {alt[2], alt[3]});
      chk({oe_all[21:20], alt_o[1:0]}, {~alt[1:0], pin_all[21:20]});
      // direction bits are all set here, so neither i2c line may get its pull-up
      chk({pull[5:3], pull[1]}, 4'h0);
    end
    wb(1'b1, 8'h33, 8'h00, q);
    chk(alt_o, 4'h3);
    end_sim();
  end
endmodule
